// file: design/asr_params.svh
// Purpose: offsets, field positions, reset values and timing for the serial receiver
// Assumes: wishbone byte address = 4 x register index, 8-bit data in low lane except the 16-bit baud register
// Notes: register index constants carry the printed or chosen offset
// Operation
// [R01] The receiver realigns its sample phase on each valid falling edge inside a character.
// [R02] Every bit lasts 16 sample ticks and the stop bit follows all earlier bits.
// [R03] The stop bit is decided by a vote of the samples at ticks eight, nine and ten.
// [R04] The length bit selects nine data bits when set and eight when clear.
// [R05] The wake select bit wakes on a set character msb when set, on an idle line when clear.
// [R06] The idle type bit starts the idle count after the stop bit when set, else after start.
// [R07] Parity enable puts a parity bit in the character msb; reset clears the enable.
// [R08] Parity sense selects odd parity when set and even when clear; reset clears it.
// [R09] A break character sets the break flag, the framing error flag and the full flag.
// [R10] In nine-bit mode a break clears the stored ninth received bit.
// [R11] The break flag raises no interrupt and clears by a status two read then a data read.
// [R12] Once cleared, the break flag sets again only after ones then another break.
// [R13] The receive active flag sets on a zero seen at the first tick of start search.
// [R14] The receive active flag clears on a false start bit or an idle character.
// [R15] Writes to status two change neither flag.
`ifndef ASR_PARAMS_SVH
`define ASR_PARAMS_SVH

// register indices
`define ASR_IDX_CTRL 6'h13
`define ASR_IDX_STAT1 6'h16
`define ASR_IDX_STAT2 6'h17
`define ASR_IDX_DATA 6'h18
`define ASR_IDX_BAUD 6'h19
`define ASR_IDX_IRQ_ST 6'h1A
`define ASR_IDX_IRQ_CLR 6'h1B
`define ASR_IDX_IRQ_EN 6'h1C

// control fields
`define ASR_CTL_CHAR9 0
`define ASR_CTL_WAKE 1
`define ASR_CTL_IDLE_COUNT_START_SELECT 2
`define ASR_CTL_PEN 3
`define ASR_CTL_PTY 4
`define ASR_CTL_RWU 5
`define ASR_CTL_NINTH 7

// status one fields
`define ASR_S1_FULL 0
`define ASR_S1_IDLE 1
`define ASR_S1_FE 2
`define ASR_S1_PE 3
`define ASR_S1_OR 4

// status two fields
`define ASR_S2_ACTIVE 0
`define ASR_S2_BREAK 1

// interrupt fields
`define ASR_IRQ_FULL 0
`define ASR_IRQ_IDLE 1
`define ASR_IRQ_ERR 2

// reset values and timing
`define ASR_CTRL_RST 8'h00
`define ASR_BAUD_RST 16'h00A2
`define ASR_TICKS_PER_BIT 16
`define ASR_SAMPLE_A 4'h7
`define ASR_SAMPLE_C 4'h9
`define ASR_BIT_LAST 4'hF
`define ASR_RESYNC_LAST 4'h6

`endif

// file: design/asr_pkg.sv
// Purpose: types shared by the serial receiver
// Assumes: nothing
// Notes: receiver state order is free
package asr_pkg;
   typedef enum logic [1:0] {
      ST_HUNT,
      ST_START,
      ST_DATA,
      ST_STOP
   } asr_state_t;
endpackage : asr_pkg

// file: design/asr_pin_sync.sv
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: pin idles high
// Notes: output changes only when stages two and three agree
module asr_pin_sync (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   input wire logic i_ce,
   // pin
   input wire logic i_pin,
   output logic o_level
);
   logic s1_q, s2_q, s3_q, lvl_q;
   logic lvl_d;

   always_comb begin
      lvl_d = lvl_q;
      if (s2_q == s3_q) begin
         lvl_d = s3_q;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         s1_q <= 1'b1;
         s2_q <= 1'b1;
         s3_q <= 1'b1;
         lvl_q <= 1'b1;
      end else if (i_ce) begin
         s1_q <= i_pin;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= lvl_d;
      end
   end

   assign o_level = lvl_q;
endmodule : asr_pin_sync

// file: design/asr_receiver.sv
// Purpose: asynchronous serial receiver with break and activity flags
// Assumes: classic wishbone slave, 32-bit data, registers in low byte, baud register in low two bytes
// Notes: sample clock is the bus clock divided by the baud register value plus one
//
// The Wishbone interface to the registers was left to the implementer.
`include "asr_params.svh"

module asr_receiver
   import asr_pkg::*;
#(
   parameter logic [15:0] BAUD_RST = `ASR_BAUD_RST
) (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   input wire logic i_ce,
   // wishbone slave
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   output logic [31:0] o_wb_dat,
   output logic o_wb_ack,
   // serial line and interrupt
   input wire logic i_receive_pin,
   output logic o_irq
);
   logic rx;

   asr_pin_sync u_sync (
      .i_clk_sys(i_clk_sys),
      .i_rst_b(i_rst_b),
      .i_ce(i_ce),
      .i_pin(i_receive_pin),
      .o_level(rx)
   );

   // state
   asr_state_t st_q, st_d;
   logic [15:0] div_q, div_d, baud_q, baud_d;
   logic [3:0] rt_q, rt_d, bit_q, bit_d, ones_q, ones_d;
   logic [1:0] vote_q, vote_d;
   logic [8:0] sh_q, sh_d;
   logic allz_q, allz_d, rxp_q, rxp_d;
   logic [6:0] ctl_q, ctl_d;
   logic ninth_q, ninth_d;
   logic [7:0] data_q, data_d;
   logic full_q, full_d, idle_q, idle_d, fe_q, fe_d, pe_q, pe_d, or_q, or_d;
   logic bkf_q, bkf_d, rpf_q, rpf_d, brk_arm_q, brk_arm_d, idl_arm_q, idl_arm_d;
   logic [4:0] s1_seen_q, s1_seen_d;
   logic bk_seen_q, bk_seen_d;
   logic [2:0] ist_q, ist_d, ien_q, ien_d;
   logic ack_q, ack_d, irq_q, irq_d;
   logic [31:0] rdat_q, rdat_d;

   // combinational helpers
   logic tick, take, rd, wr, bit_val, edge_fall, char9, stop_ok, is_brk, deliver, msb;
   logic [3:0] nb, frame;
   logic [8:0] chr;
   logic [5:0] idx;
   logic [2:0] ev;
   logic [4:0] s1_now;
   logic [7:0] rsel;

   always_comb begin
      st_d = st_q;
      div_d = div_q;
      baud_d = baud_q;
      rt_d = rt_q;
      bit_d = bit_q;
      ones_d = ones_q;
      vote_d = vote_q;
      sh_d = sh_q;
      allz_d = allz_q;
      rxp_d = rxp_q;
      ctl_d = ctl_q;
      ninth_d = ninth_q;
      data_d = data_q;
      full_d = full_q;
      idle_d = idle_q;
      fe_d = fe_q;
      pe_d = pe_q;
      or_d = or_q;
      bkf_d = bkf_q;
      rpf_d = rpf_q;
      brk_arm_d = brk_arm_q;
      idl_arm_d = idl_arm_q;
      s1_seen_d = s1_seen_q;
      bk_seen_d = bk_seen_q;
      ien_d = ien_q;
      rdat_d = rdat_q;
      ev = 3'h0;
      chr = 9'h000;
      stop_ok = 1'b0;
      is_brk = 1'b0;
      deliver = 1'b0;
      msb = 1'b0;
      rsel = 8'h00;

      char9 = ctl_q[`ASR_CTL_CHAR9];
      nb = char9 ? 4'h9 : 4'h8; // R04
      frame = nb + 4'h2;
      idx = i_wb_adr[7:2];
      take = i_wb_cyc && i_wb_stb && !ack_q;
      rd = take && !i_wb_we;
      wr = take && i_wb_we && i_wb_sel[0];
      ack_d = take;

      // sample clock divider
      tick = (div_q == 16'h0000);
      div_d = tick ? baud_q : div_q - 16'h0001;
      bit_val = vote_q[1]; // R03
      edge_fall = rxp_q && !rx;

      if (tick) begin
         rxp_d = rx;
         if (rx && !bkf_q) begin
            brk_arm_d = 1'b1; // R12
         end
         if (rt_q >= `ASR_SAMPLE_A && rt_q <= `ASR_SAMPLE_C) begin
            vote_d = vote_q + {1'b0, rx};
         end
         rt_d = rt_q + 4'h1; // R02
         case (st_q)
            ST_HUNT: begin
               if (!rx) begin
                  st_d = ST_START;
                  rpf_d = 1'b1; // R13
                  rt_d = 4'h1;
                  vote_d = 2'h0;
                  idl_arm_d = 1'b1;
               end else if (rt_q == `ASR_BIT_LAST && ones_q != 4'hF) begin
                  ones_d = ones_q + 4'h1;
               end
            end
            ST_START: begin
               if (rt_q == `ASR_BIT_LAST) begin
                  vote_d = 2'h0;
                  if (bit_val) begin
                     st_d = ST_HUNT;
                     rpf_d = 1'b0; // R14
                     ones_d = 4'h0;
                  end else begin
                     st_d = ST_DATA;
                     bit_d = 4'h0;
                     allz_d = 1'b1;
                     ones_d = 4'h0;
                  end
               end
            end
            ST_DATA, ST_STOP: begin
               if (edge_fall && rt_q != 4'h0 && rt_q <= `ASR_RESYNC_LAST) begin
                  rt_d = 4'h1; // R01
                  vote_d = 2'h0;
               end else if (rt_q == `ASR_BIT_LAST) begin
                  vote_d = 2'h0;
                  if (!ctl_q[`ASR_CTL_IDLE_COUNT_START_SELECT]) begin
                     ones_d = bit_val ? ones_q + 4'h1 : 4'h0; // R06
                  end
                  if (st_q == ST_DATA) begin
                     sh_d = {bit_val, sh_q[8:1]};
                     allz_d = allz_q && !bit_val;
                     bit_d = bit_q + 4'h1;
                     if (bit_q == nb - 4'h1) begin
                        st_d = ST_STOP; // R02
                     end
                  end else begin
                     st_d = ST_HUNT;
                     stop_ok = bit_val; // R03
                     chr = char9 ? sh_q : {1'b0, sh_q[8:1]};
                     msb = char9 ? chr[8] : chr[7];
                     is_brk = allz_q && !stop_ok;
                     if (ctl_q[`ASR_CTL_IDLE_COUNT_START_SELECT]) begin
                        ones_d = 4'h0; // R06
                     end
                     if (ctl_q[`ASR_CTL_RWU] && ctl_q[`ASR_CTL_WAKE] && msb) begin
                        ctl_d[`ASR_CTL_RWU] = 1'b0; // R05
                     end
                     deliver = !ctl_q[`ASR_CTL_RWU] || (ctl_q[`ASR_CTL_WAKE] && msb);
                     if (is_brk) begin
                        full_d = 1'b1; // R09
                        fe_d = 1'b1; // R09
                        data_d = 8'h00;
                        if (char9) begin
                           ninth_d = 1'b0; // R10
                        end
                        if (brk_arm_q) begin
                           bkf_d = 1'b1; // R09
                           brk_arm_d = 1'b0; // R12
                        end
                        ev = 3'h5;
                     end else if (deliver) begin
                        if (full_q) begin
                           or_d = 1'b1;
                           ev[`ASR_IRQ_ERR] = 1'b1;
                        end else begin
                           data_d = chr[7:0];
                           ninth_d = char9 ? chr[8] : ninth_q;
                           full_d = 1'b1;
                           fe_d = !stop_ok;
                           // R07 R08 msb is parity, odd sense wants odd ones
                           pe_d = ctl_q[`ASR_CTL_PEN] &&
                                  ((^chr) != ctl_q[`ASR_CTL_PTY]);
                           ev[`ASR_IRQ_FULL] = 1'b1;
                           ev[`ASR_IRQ_ERR] = !stop_ok || pe_d;
                        end
                     end
                  end
               end
            end
            default: st_d = ST_HUNT;
         endcase
         if (st_q == ST_HUNT && rx && ones_q >= frame && idl_arm_q) begin
            idle_d = 1'b1;
            idl_arm_d = 1'b0;
            rpf_d = 1'b0; // R14
            ev[`ASR_IRQ_IDLE] = 1'b1;
            if (!ctl_q[`ASR_CTL_WAKE]) begin
               ctl_d[`ASR_CTL_RWU] = 1'b0; // R05
            end
         end
      end

      // register reads and their side effects
      s1_now = {or_q, pe_q, fe_q, idle_q, full_q};
      case (idx)
         `ASR_IDX_CTRL: rsel = {ninth_q, ctl_q};
         `ASR_IDX_STAT1: rsel = {3'h0, s1_now};
         `ASR_IDX_STAT2: rsel = {6'h00, bkf_q, rpf_q};
         `ASR_IDX_DATA: rsel = data_q;
         `ASR_IDX_BAUD: rsel = baud_q[7:0];
         `ASR_IDX_IRQ_ST: rsel = {5'h00, ist_q};
         `ASR_IDX_IRQ_EN: rsel = {5'h00, ien_q};
         default: rsel = 8'h00;
      endcase
      if (rd) begin
         rdat_d = (idx == `ASR_IDX_BAUD) ? {16'h0000, baud_q} : {24'h000000, rsel};
         if (idx == `ASR_IDX_STAT1) begin
            s1_seen_d = s1_now;
         end
         if (idx == `ASR_IDX_STAT2 && bkf_q) begin
            bk_seen_d = 1'b1; // R11
         end
         if (idx == `ASR_IDX_DATA) begin
            // flags seen earlier clear, a new event this cycle wins
            full_d = full_d && !(s1_seen_q[`ASR_S1_FULL] && full_q && !ev[0]);
            idle_d = idle_d && !(s1_seen_q[`ASR_S1_IDLE] && !ev[1]);
            fe_d = fe_d && !(s1_seen_q[`ASR_S1_FE] && !ev[2]);
            pe_d = pe_d && !(s1_seen_q[`ASR_S1_PE] && !ev[2]);
            or_d = or_d && !(s1_seen_q[`ASR_S1_OR] && !ev[2]);
            s1_seen_d = 5'h00;
            if (bk_seen_q && !(bkf_d && !bkf_q)) begin
               bkf_d = 1'b0; // R11
            end
            bk_seen_d = 1'b0;
         end
      end

      // register writes; status two is read-only
      if (wr) begin
         case (idx)
            `ASR_IDX_CTRL: ctl_d = i_wb_dat[6:0];
            `ASR_IDX_BAUD: baud_d = {i_wb_sel[1] ? i_wb_dat[15:8] : baud_q[15:8],
                                     i_wb_dat[7:0]};
            `ASR_IDX_IRQ_EN: ien_d = i_wb_dat[2:0];
            default: ; // R15
         endcase
      end

      // sticky events: set wins over clear; break raises full and error
      ist_d = ist_q | ev; // R11
      if (wr && idx == `ASR_IDX_IRQ_CLR) begin
         ist_d = (ist_q & ~i_wb_dat[2:0]) | ev;
      end
      irq_d = |(ist_d & ien_d);
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_q <= ST_HUNT;
         div_q <= 16'h0000;
         baud_q <= BAUD_RST;
         rt_q <= 4'h0;
         bit_q <= 4'h0;
         ones_q <= 4'h0;
         vote_q <= 2'h0;
         sh_q <= 9'h000;
         allz_q <= 1'b0;
         rxp_q <= 1'b1;
         ctl_q <= 7'(`ASR_CTRL_RST); // R05 R06 R07 R08
         ninth_q <= 1'b0;
         data_q <= 8'h00;
         full_q <= 1'b0;
         idle_q <= 1'b0;
         fe_q <= 1'b0;
         pe_q <= 1'b0;
         or_q <= 1'b0;
         bkf_q <= 1'b0; // R11
         rpf_q <= 1'b0;
         brk_arm_q <= 1'b1;
         idl_arm_q <= 1'b0;
         s1_seen_q <= 5'h00;
         bk_seen_q <= 1'b0;
         ist_q <= 3'h0;
         ien_q <= 3'h0;
         ack_q <= 1'b0;
         irq_q <= 1'b0;
         rdat_q <= 32'h00000000;
      end else if (i_ce) begin
         st_q <= st_d;
         div_q <= div_d;
         baud_q <= baud_d;
         rt_q <= rt_d;
         bit_q <= bit_d;
         ones_q <= ones_d;
         vote_q <= vote_d;
         sh_q <= sh_d;
         allz_q <= allz_d;
         rxp_q <= rxp_d;
         ctl_q <= ctl_d;
         ninth_q <= ninth_d;
         data_q <= data_d;
         full_q <= full_d;
         idle_q <= idle_d;
         fe_q <= fe_d;
         pe_q <= pe_d;
         or_q <= or_d;
         bkf_q <= bkf_d;
         rpf_q <= rpf_d;
         brk_arm_q <= brk_arm_d;
         idl_arm_q <= idl_arm_d;
         s1_seen_q <= s1_seen_d;
         bk_seen_q <= bk_seen_d;
         ist_q <= ist_d;
         ien_q <= ien_d;
         ack_q <= ack_d;
         irq_q <= irq_d;
         rdat_q <= rdat_d;
      end
   end

   assign o_wb_ack = ack_q;
   assign o_wb_dat = rdat_q;
   assign o_irq = irq_q;
endmodule : asr_receiver

// file: bench/asr_line_model.sv
// Purpose: remote serial transmitter driving the receive pin
// Assumes: one sample tick per clock, so a bit lasts per clocks
// Notes: line held high between frames
module asr_line_model (
   // clock
   input wire logic i_clk_sys,
   // line
   output logic o_pin
);
   timeunit 1ns;
   timeprecision 1ps;
   initial o_pin = 1'b1;
   task automatic drive(input logic v, input int n);
      @(posedge i_clk_sys);
      o_pin <= v;
      repeat (n - 1) @(posedge i_clk_sys);
   endtask : drive
   // start, nb bits lsb first, stop, then a bit of idle ones
   task automatic send(input logic [9:0] d, input int nb, input int per, input logic stp);
      drive(1'b0, per);
      for (int i = 0; i < nb; i++) begin
         drive(d[i], per);
      end
      drive(stp, per);
      drive(1'b1, per);
   endtask : send
endmodule : asr_line_model

// file: bench/asr_receiver_asserts.sv
// Purpose: bus and interrupt checks on the receiver ports
// Assumes: classic single-cycle bus master
// Notes: enable register mirrored from bus writes
module asr_receiver_chk (
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   input wire logic i_ce,
   // bus
   input wire logic i_wb_cyc,
   input wire logic i_wb_stb,
   input wire logic i_wb_we,
   input wire logic [7:0] i_wb_adr,
   input wire logic [3:0] i_wb_sel,
   input wire logic [31:0] i_wb_dat,
   input wire logic [31:0] o_wb_dat,
   input wire logic o_wb_ack,
   // line and interrupt
   input wire logic i_receive_pin,
   input wire logic o_irq
);
   logic take;
   logic rd_ack;
   logic [2:0] en_q;
   logic [2:0] en_d;
   assign take = i_ce && i_wb_cyc && i_wb_stb && !o_wb_ack;
   assign rd_ack = o_wb_ack && !i_wb_we;
   always_comb begin
      en_d = en_q;
      if (take && i_wb_we && i_wb_sel[0] && i_wb_adr[7:2] == 6'h1C) begin
         en_d = i_wb_dat[2:0];
      end
   end
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         en_q <= 3'h0;
      end else begin
         en_q <= en_d;
      end
   end
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_b);
   AST_ACK_NEXT: assert property (take |=> o_wb_ack) else $error("ack late");
   AST_ACK_PULSE: assert property (o_wb_ack && i_ce |=> !o_wb_ack) else $error("ack long");
   AST_ACK_CAUSE: assert property (!take && !o_wb_ack |=> !o_wb_ack) else $error("stray ack");
   AST_ACK_REQ: assert property (o_wb_ack |-> i_wb_cyc && i_wb_stb) else $error("ack no cyc");
   AST_DAT_HIGH: assert property (o_wb_ack |-> o_wb_dat[31:16] == 16'h0000)
      else $error("high data set");
   AST_S2_BITS: assert property (rd_ack && i_wb_adr == 8'h5C |-> o_wb_dat[31:2] == 30'h0)
      else $error("status two wide");
   AST_S1_BITS: assert property (rd_ack && i_wb_adr == 8'h58 |-> o_wb_dat[31:5] == 27'h0)
      else $error("status one wide");
   AST_UNMAPPED: assert property (rd_ack && i_wb_adr == 8'h00 |-> o_wb_dat == 32'h0)
      else $error("unmapped data");
   AST_IRQ_MASK: assert property (en_q == 3'h0 |-> !o_irq)
      else $error("irq while masked");
endmodule : asr_receiver_chk
bind asr_receiver asr_receiver_chk asr_receiver_chk_inst (
   .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_ce(i_ce), .i_wb_cyc(i_wb_cyc),
   .i_wb_stb(i_wb_stb), .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel),
   .i_wb_dat(i_wb_dat), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack),
   .i_receive_pin(i_receive_pin), .o_irq(o_irq));

// file: bench/asr_receiver_test.sv
// Purpose: self-checking bench for the serial receiver
// Assumes: baud divisor 0, one sample tick per clock
// Notes: expected bytes queued as frames are sent
module asr_receiver_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst_b, ce, cyc, stb, we, ack, irq, pin, par;
   logic [7:0] adr, d;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, got;
   logic [15:0] lfsr_q = 16'hBCAB;
   int n_fail, compares;
   int exp_q[$];
   asr_receiver asr_receiver_inst (.i_clk_sys(clk), .i_rst_b(rst_b), .i_ce(ce),
      .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel),
      .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .i_receive_pin(pin), .o_irq(irq));
   asr_line_model asr_line_model_inst (.i_clk_sys(clk), .o_pin(pin));
   function automatic logic [7:0] rnd();
      lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      return lfsr_q[7:0];
   endfunction : rnd
   task automatic print_verdict();
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : print_verdict
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
      int n;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= v;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      got = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (ack !== 1'b1) begin
         n_fail++;
         print_verdict();
      end
   endtask : bus
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(nm, e, got & m);
   endtask : rd
   task automatic rdata();
      bus(1'b0, 8'h60, 32'h0);
      chk("data", exp_q.pop_front(), got & 32'hFF);
   endtask : rdata
   task automatic irq_is(input logic e);
      repeat (4) @(posedge clk);
      chk("irq", {31'h0, e}, {31'h0, irq});
   endtask : irq_is
   // frame, wait for full interrupt, then clear it
   task automatic rx(input logic [9:0] v, input int nb, input int per, input logic stp);
      int n;
      asr_line_model_inst.send(v, nb, per, stp);
      n = 0;
      while (irq !== 1'b1 && n < 400) begin
         @(posedge clk);
         n++;
      end
      chk("irq_full", 32'h1, {31'h0, irq});
      bus(1'b1, 8'h6C, 32'h7);
   endtask : rx
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      rst_b = 1'b0;
      {cyc, stb, we, adr, wdat, n_fail, compares} = '0;
      sel = 4'h3;
      ce = 1'b1;
      repeat (16) @(posedge clk);
      rst_b <= 1'b1;
      rd("ctrl", 8'h4C, 32'hFF, 32'h0);
      rd("stat2", 8'h5C, 32'hFF, 32'h0);
      rd("baud", 8'h64, 32'hFFFF, 32'h00A2);
      rd("irq_en", 8'h70, 32'hFF, 32'h0);
      rd("unmapped", 8'h00, 32'hFFFFFFFF, 32'h0);
      bus(1'b1, 8'h5C, 32'hFF);
      rd("stat2_wr", 8'h5C, 32'hFF, 32'h0);
      bus(1'b1, 8'h64, 32'h0);
      // request raised while frozen gets no answer until enabled
      @(posedge clk);
      ce <= 1'b0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= 1'b0;
      adr <= 8'h64;
      repeat (6) @(posedge clk);
      chk("ce_hold", 32'h0, {31'h0, ack});
      ce <= 1'b1;
      bus(1'b0, 8'h64, 32'h0);
      chk("baud_wr", 32'h0, got & 32'hFFFF);
      bus(1'b1, 8'h70, 32'h1);
      // old divisor count runs out before the new one applies
      repeat (200) @(posedge clk);
      $display("registers done");
      for (int i = 0; i < 4; i++) begin
         d = (i == 3) ? 8'h55 : rnd();
         exp_q.push_back(d);
         rx({2'b00, d}, 8, (i == 3) ? 17 : 16, 1'b1);
         rd("stat1", 8'h58, 32'h1D, 32'h1);
         rdata();
      end
      $display("plain frames done");
      exp_q.push_back(8'hA5);
      fork
         rx(10'h0A5, 8, 16, 1'b1);
         begin
            repeat (40) @(posedge clk);
            rd("active", 8'h5C, 32'h1, 32'h1);
         end
      join
      rd("stat1", 8'h58, 32'h1D, 32'h1);
      rdata();
      repeat (240) @(posedge clk);
      rd("idle_active", 8'h5C, 32'h1, 32'h0);
      rd("idle", 8'h58, 32'h2, 32'h2);
      bus(1'b0, 8'h60, 32'h0);
      asr_line_model_inst.drive(1'b0, 4);
      asr_line_model_inst.drive(1'b1, 4);
      rd("false_set", 8'h5C, 32'h1, 32'h1);
      asr_line_model_inst.drive(1'b1, 60);
      rd("false_start", 8'h5C, 32'h1, 32'h0);
      rd("false_full", 8'h58, 32'h1, 32'h0);
      $display("activity done");
      for (int k = 0; k < 2; k++) begin
         bus(1'b1, 8'h4C, 32'h09 | (k << 4));
         d = rnd();
         par = ^d ^ k[0];
         exp_q.push_back(d);
         rx({1'b0, par, d}, 9, 16, 1'b1);
         rd("ctrl9", 8'h4C, 32'hFF, {24'h0, par, 2'b00, k[0], 4'h9});
         rd("par_ok", 8'h58, 32'h0D, 32'h1);
         rdata();
         exp_q.push_back(d);
         rx({1'b0, ~par, d}, 9, 16, 1'b1);
         rd("par_bad", 8'h58, 32'h08, 32'h8);
         rdata();
      end
      bus(1'b1, 8'h4C, 32'h06);
      rd("ctrl_wake", 8'h4C, 32'h7F, 32'h06);
      // asleep with mark wakeup: clear msb dropped, set msb wakes
      bus(1'b1, 8'h4C, 32'h26);
      asr_line_model_inst.send(10'h041, 8, 16, 1'b1);
      rd("asleep", 8'h58, 32'h1, 32'h0);
      exp_q.push_back(8'hC1);
      rx(10'h0C1, 8, 16, 1'b1);
      rd("woken", 8'h4C, 32'h7F, 32'h06);
      rd("woken_s1", 8'h58, 32'h1D, 32'h1);
      rdata();
      $display("parity done");
      bus(1'b1, 8'h4C, 32'h01);
      exp_q.push_back(8'h00);
      rx(10'h100, 9, 16, 1'b1);
      rd("ninth", 8'h4C, 32'h80, 32'h80);
      rd("stat1", 8'h58, 32'h1D, 32'h1);
      rdata();
      exp_q.push_back(8'h00);
      rx(10'h000, 9, 16, 1'b0);
      rd("brk", 8'h5C, 32'h2, 32'h2);
      rd("brk_s1", 8'h58, 32'h5, 32'h5);
      rd("brk_ninth", 8'h4C, 32'hFF, 32'h1);
      rdata();
      rd("brk_clr", 8'h5C, 32'h2, 32'h0);
      $display("break done");
      bus(1'b1, 8'h4C, 32'h0);
      exp_q.push_back(8'h3C);
      asr_line_model_inst.send(10'h03C, 8, 16, 1'b1);
      irq_is(1'b1);
      rd("irq_st", 8'h68, 32'h7, 32'h1);
      bus(1'b1, 8'h70, 32'h0);
      irq_is(1'b0);
      bus(1'b1, 8'h70, 32'h1);
      irq_is(1'b1);
      bus(1'b1, 8'h6C, 32'h7);
      irq_is(1'b0);
      rd("irq_clr", 8'h6C, 32'hFF, 32'h0);
      rd("irq_st0", 8'h68, 32'h7, 32'h0);
      rd("stat1", 8'h58, 32'h1D, 32'h1);
      rdata();
      $display("interrupt done");
      print_verdict();
   end
endmodule : asr_receiver_test
